// ===== rtl/bit_shift_flag_consts.svh
`ifndef BIT_SHIFT_FLAG_CONSTS_SVH
`define BIT_SHIFT_FLAG_CONSTS_SVH

// ----------------------------------------
// status flag bit positions
// ----------------------------------------
`define FLAG_C 3'd0
`define FLAG_Z 3'd1
`define FLAG_N 3'd2
`define FLAG_V 3'd3
`define FLAG_S 3'd4
`define FLAG_H 3'd5
`define FLAG_T 3'd6
`define FLAG_I 3'd7

// ----------------------------------------
// apb register byte offsets
// ----------------------------------------
`define OFS_STATUS 8'h00
`define OFS_CTRL 8'h04
`define OFS_OP_COUNT 8'h08
`define OFS_LAST_RESULT 8'h0c

// ----------------------------------------
// control fields and reset values
// ----------------------------------------
`define CTRL_EXEC_EN_BIT 0
`define CTRL_SRAM_XTRA_BIT 1
`define RST_STATUS 8'h00
`define RST_CTRL 2'h3

// ----------------------------------------
// timing
// ----------------------------------------
`define EXEC_CYCLES 1
`define SRAM_EXTRA_CYCLES 4'h1

`endif

// ===== rtl/bit_shift_flag_pkg.sv
package bit_shift_flag_pkg;

  typedef enum logic [4:0] {
    op_none,
    op_rotate_left_carry,
    op_rotate_right_carry,
    op_arith_shift_right,
    op_io_bit_set,
    op_io_bit_clear,
    op_bit_store_to_transfer,
    op_bit_load_from_transfer,
    op_indexed_flag_set,
    op_indexed_flag_clear,
    op_overflow_flag_set,
    op_overflow_flag_clear,
    op_half_carry_set,
    op_half_carry_clear,
    op_sign_flag_set,
    op_sign_flag_clear,
    op_carry_set,
    op_carry_clear,
    op_negative_set,
    op_negative_clear,
    op_zero_set,
    op_zero_clear,
    op_global_irq_enable,
    op_global_irq_disable,
    op_transfer_set,
    op_transfer_clear
  } op_t;

  typedef enum logic [1:0] {
    shift_rotate_left,
    shift_rotate_right,
    shift_arith_right
  } shift_kind_t;

  typedef enum {
    mem_idle,
    mem_count,
    mem_ext_wait
  } mem_state_t;

endpackage

// ===== rtl/shift_rotate_core.sv
`timescale 1ns/1ps
`include "bit_shift_flag_consts.svh"

module shift_rotate_core
  import bit_shift_flag_pkg::*;
(
  // operation
  input wire shift_kind_t kind,
  input wire logic [7:0] operand,
  input wire logic carry_in,
  input wire logic [7:0] flags_in,
  // result
  output logic [7:0] result,
  output logic [7:0] flags_out
);

  logic carry_out;

  always_comb
  begin
    flags_out = flags_in;
    case (kind)
      shift_rotate_left:
      begin
        result = {operand[6:0], carry_in};
        carry_out = operand[7];
        flags_out[`FLAG_H] = operand[3];
      end
      shift_rotate_right:
      begin
        result = {carry_in, operand[7:1]};
        carry_out = operand[0];
      end
      shift_arith_right:
      begin
        result = {operand[7], operand[7:1]};
        carry_out = operand[0];
      end
      default:
      begin
        result = operand;
        carry_out = carry_in;
      end
    endcase
    // z, c, n and v are common to all three; h only for rotate left
    flags_out[`FLAG_C] = carry_out;
    flags_out[`FLAG_Z] = (result == 8'h00);
    flags_out[`FLAG_N] = result[7];
    flags_out[`FLAG_V] = result[7] ^ carry_out;
  end

endmodule

// ===== rtl/bit_shift_flag_unit.sv
`timescale 1ns/1ps
`include "bit_shift_flag_consts.svh"

module bit_shift_flag_unit
  import bit_shift_flag_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // instruction from decoder
  input wire logic op_valid,
  input wire op_t op_code,
  input wire logic [7:0] reg_in,
  input wire logic [2:0] bit_sel,
  input wire logic [2:0] flag_sel,
  // io space read-modify-write
  input wire logic [5:0] io_addr_in,
  input wire logic [7:0] io_data_in,
  output logic [5:0] io_addr,
  output logic [7:0] io_wr_data,
  output logic io_we,
  // register file write back
  output logic [7:0] reg_out,
  output logic reg_we,
  output logic op_done,
  // status flags
  output logic [7:0] status_flags,
  // data memory access timing
  input wire logic mem_req,
  input wire logic [3:0] mem_base_cycles,
  input wire logic mem_internal_sram,
  input wire logic mem_external,
  input wire logic ext_ack,
  output logic mem_done
);

  // ----------------------------------------
  // shifter
  // ----------------------------------------
  shift_kind_t shift_kind;
  logic [7:0] shift_result;
  logic [7:0] shift_flags;
  logic [7:0] status_flags_r;

  always_comb
  begin
    case (op_code)
      op_rotate_right_carry: shift_kind = shift_rotate_right;
      op_arith_shift_right: shift_kind = shift_arith_right;
      default: shift_kind = shift_rotate_left;
    endcase
  end

  shift_rotate_core u_shift (
    .kind(shift_kind),
    .operand(reg_in),
    .carry_in(status_flags_r[`FLAG_C]),
    .flags_in(status_flags_r),
    .result(shift_result),
    .flags_out(shift_flags)
  );

  // ----------------------------------------
  // apb registers
  // ----------------------------------------
  logic [1:0] ctrl_r, ctrl_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [31:0] op_count_r, op_count_nxt;
  logic [7:0] last_result_r, last_result_nxt;
  logic apb_wr_status;
  logic exec;
  logic mapped;

  assign exec = op_valid & ctrl_r[`CTRL_EXEC_EN_BIT];

  always_comb
  begin
    mapped = (paddr == `OFS_STATUS) || (paddr == `OFS_CTRL) ||
             (paddr == `OFS_OP_COUNT) || (paddr == `OFS_LAST_RESULT);
    ctrl_nxt = ctrl_r;
    prdata_nxt = prdata_r;
    pslverr_nxt = pslverr_r;
    apb_wr_status = 1'b0;
    // one wait state keeps pready a plain flip-flop output
    pready_nxt = psel & penable & ~pready_r;
    if (psel & penable & ~pready_r)
    begin
      pslverr_nxt = ~mapped;
      case (paddr)
        `OFS_STATUS: prdata_nxt = {24'h000000, status_flags_r};
        `OFS_CTRL: prdata_nxt = {30'h0, ctrl_r};
        `OFS_OP_COUNT: prdata_nxt = op_count_r;
        `OFS_LAST_RESULT: prdata_nxt = {24'h000000, last_result_r};
        default: prdata_nxt = 32'h00000000;
      endcase
    end
    if (psel & penable & pready_r & pwrite)
    begin
      case (paddr)
        `OFS_STATUS: apb_wr_status = 1'b1;
        `OFS_CTRL: ctrl_nxt = pwdata[1:0];
        default: ctrl_nxt = ctrl_r;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      ctrl_r <= `RST_CTRL;
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  // ----------------------------------------
  // execution
  // ----------------------------------------
  logic [7:0] status_nxt;
  logic [7:0] flags_exec;
  logic flags_touched;
  logic [5:0] io_addr_r, io_addr_nxt;
  logic [7:0] io_wr_data_r, io_wr_data_nxt;
  logic io_we_r, io_we_nxt;
  logic [7:0] reg_out_r, reg_out_nxt;
  logic reg_we_r, reg_we_nxt;
  logic op_done_r, op_done_nxt;
  logic [7:0] bit_mask;

  assign bit_mask = 8'h01 << bit_sel;

  always_comb
  begin
    flags_exec = status_flags_r;
    flags_touched = 1'b0;
    io_addr_nxt = io_addr_r;
    io_wr_data_nxt = io_wr_data_r;
    io_we_nxt = 1'b0;
    reg_out_nxt = reg_out_r;
    reg_we_nxt = 1'b0;
    op_done_nxt = 1'b0;
    last_result_nxt = last_result_r;
    op_count_nxt = op_count_r;
    if (exec && op_code != op_none)
    begin
      op_done_nxt = 1'b1;
      op_count_nxt = op_count_r + 32'h00000001;
      flags_touched = 1'b1;
      case (op_code)
        op_rotate_left_carry, op_rotate_right_carry, op_arith_shift_right:
        begin
          reg_out_nxt = shift_result;
          reg_we_nxt = 1'b1;
          flags_exec = shift_flags;
          last_result_nxt = shift_result;
        end
        op_io_bit_set:
        begin
          io_addr_nxt = io_addr_in;
          io_wr_data_nxt = io_data_in | bit_mask;
          io_we_nxt = 1'b1;
          last_result_nxt = io_data_in | bit_mask;
          flags_touched = 1'b0;
        end
        op_io_bit_clear:
        begin
          io_addr_nxt = io_addr_in;
          io_wr_data_nxt = io_data_in & ~bit_mask;
          io_we_nxt = 1'b1;
          last_result_nxt = io_data_in & ~bit_mask;
          flags_touched = 1'b0;
        end
        op_bit_store_to_transfer: flags_exec[`FLAG_T] = reg_in[bit_sel];
        op_bit_load_from_transfer:
        begin
          // only the selected bit follows t, the rest pass through
          reg_out_nxt = status_flags_r[`FLAG_T] ? (reg_in | bit_mask) : (reg_in & ~bit_mask);
          reg_we_nxt = 1'b1;
          last_result_nxt = reg_out_nxt;
          flags_touched = 1'b0;
        end
        op_indexed_flag_set: flags_exec[flag_sel] = 1'b1;
        op_indexed_flag_clear: flags_exec[flag_sel] = 1'b0;
        op_overflow_flag_set: flags_exec[`FLAG_V] = 1'b1;
        op_overflow_flag_clear: flags_exec[`FLAG_V] = 1'b0;
        op_half_carry_set: flags_exec[`FLAG_H] = 1'b1;
        op_half_carry_clear: flags_exec[`FLAG_H] = 1'b0;
        op_sign_flag_set: flags_exec[`FLAG_S] = 1'b1;
        op_sign_flag_clear: flags_exec[`FLAG_S] = 1'b0;
        op_carry_set: flags_exec[`FLAG_C] = 1'b1;
        op_carry_clear: flags_exec[`FLAG_C] = 1'b0;
        op_negative_set: flags_exec[`FLAG_N] = 1'b1;
        op_negative_clear: flags_exec[`FLAG_N] = 1'b0;
        op_zero_set: flags_exec[`FLAG_Z] = 1'b1;
        op_zero_clear: flags_exec[`FLAG_Z] = 1'b0;
        op_global_irq_enable: flags_exec[`FLAG_I] = 1'b1;
        op_global_irq_disable: flags_exec[`FLAG_I] = 1'b0;
        op_transfer_set: flags_exec[`FLAG_T] = 1'b1;
        op_transfer_clear: flags_exec[`FLAG_T] = 1'b0;
        default:
        begin
          op_done_nxt = 1'b0;
          op_count_nxt = op_count_r;
          flags_touched = 1'b0;
        end
      endcase
    end
    // core update beats a software write landing in the same cycle
    if (flags_touched)
      status_nxt = flags_exec;
    else if (apb_wr_status)
      status_nxt = pwdata[7:0];
    else
      status_nxt = status_flags_r;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      status_flags_r <= `RST_STATUS;
      io_addr_r <= 6'h00;
      io_wr_data_r <= 8'h00;
      io_we_r <= 1'b0;
      reg_out_r <= 8'h00;
      reg_we_r <= 1'b0;
      op_done_r <= 1'b0;
      op_count_r <= 32'h00000000;
      last_result_r <= 8'h00;
    end
    else
    begin
      status_flags_r <= status_nxt;
      io_addr_r <= io_addr_nxt;
      io_wr_data_r <= io_wr_data_nxt;
      io_we_r <= io_we_nxt;
      reg_out_r <= reg_out_nxt;
      reg_we_r <= reg_we_nxt;
      op_done_r <= op_done_nxt;
      op_count_r <= op_count_nxt;
      last_result_r <= last_result_nxt;
    end
  end

  assign status_flags = status_flags_r;
  assign io_addr = io_addr_r;
  assign io_wr_data = io_wr_data_r;
  assign io_we = io_we_r;
  assign reg_out = reg_out_r;
  assign reg_we = reg_we_r;
  assign op_done = op_done_r;

  // ----------------------------------------
  // data memory access timing
  // ----------------------------------------
  mem_state_t mem_state_r, mem_state_nxt;
  logic [4:0] mem_cnt_r, mem_cnt_nxt;
  logic mem_done_r, mem_done_nxt;
  logic [4:0] mem_total;

  always_comb
  begin
    // a base count of zero is treated as one cycle
    mem_total = (mem_base_cycles == 4'h0) ? 5'd1 : {1'b0, mem_base_cycles};
    if (mem_internal_sram && ctrl_r[`CTRL_SRAM_XTRA_BIT])
      mem_total = mem_total + {1'b0, `SRAM_EXTRA_CYCLES};
    mem_state_nxt = mem_state_r;
    mem_cnt_nxt = mem_cnt_r;
    mem_done_nxt = 1'b0;
    case (mem_state_r)
      mem_idle:
      begin
        if (mem_req && mem_external)
          mem_state_nxt = mem_ext_wait;
        else if (mem_req)
        begin
          mem_cnt_nxt = mem_total;
          mem_state_nxt = mem_count;
        end
      end
      mem_count:
      begin
        if (mem_cnt_r <= 5'd1)
        begin
          mem_done_nxt = 1'b1;
          mem_state_nxt = mem_idle;
        end
        else
          mem_cnt_nxt = mem_cnt_r - 5'd1;
      end
      mem_ext_wait:
      begin
        // external ram sets its own pace, no fixed count applies
        if (ext_ack)
        begin
          mem_done_nxt = 1'b1;
          mem_state_nxt = mem_idle;
        end
      end
      default: mem_state_nxt = mem_idle;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      mem_state_r <= mem_idle;
      mem_cnt_r <= 5'd0;
      mem_done_r <= 1'b0;
    end
    else
    begin
      mem_state_r <= mem_state_nxt;
      mem_cnt_r <= mem_cnt_nxt;
      mem_done_r <= mem_done_nxt;
    end
  end

  assign mem_done = mem_done_r;

endmodule

// ===== tb/io_space_model.sv
`timescale 1ns/1ps
module io_space_model
(
  // clock
  input wire logic sys_clk,
  // read side
  input wire logic [5:0] rd_addr,
  output logic [7:0] rd_data,
  // write side
  input wire logic [5:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic we
);
  logic [7:0] regs_r [64];

  // mixed start pattern so both set and clear really flip bits
  initial
  begin
    for (int i = 0; i < 64; i++)
      regs_r[i] = 8'(i * 37 + 90);
  end
  assign rd_data = regs_r[rd_addr];
  always @(posedge sys_clk)
    if (we)
      regs_r[wr_addr] <= wr_data;
endmodule

// ===== tb/bit_shift_flag_unit_sva.sv
`timescale 1ns/1ps
module bit_shift_flag_unit_chk
  import bit_shift_flag_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // instruction
  input wire logic op_valid,
  input wire op_t op_code,
  input wire logic [7:0] reg_in,
  input wire logic [2:0] bit_sel,
  input wire logic [2:0] flag_sel,
  input wire logic [7:0] io_data_in,
  // results
  input wire logic [7:0] io_wr_data,
  input wire logic io_we,
  input wire logic [7:0] reg_out,
  input wire logic reg_we,
  input wire logic op_done,
  input wire logic [7:0] status_flags,
  // memory timing
  input wire logic mem_req,
  input wire logic [3:0] mem_base_cycles,
  input wire logic mem_internal_sram,
  input wire logic mem_external,
  input wire logic mem_done
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  // dedicated pairs run v h s c n z i t: flag positions packed 3 bits each
  function automatic logic [7:0] fexp(op_t c, logic [2:0] s, logic [7:0] f);
    f[(c < op_overflow_flag_set) ? s : 3'(24'hdca12b >> (3 * ((int'(c) - 10) / 2)))] = ~c[0];
    return f;
  endfunction

  property p_cause;
    op_done |-> $past(op_valid) && $past(op_code) != op_none;
  endproperty
  a_cause: assert property (p_cause) else $error("done without op");
  property p_rol;
    op_done && $past(op_code) == op_rotate_left_carry |-> reg_we && status_flags[0] == $past(reg_in[7])
      && reg_out == {$past(reg_in[6:0]), $past(status_flags[0])} && status_flags[5] == $past(reg_in[3]);
  endproperty
  a_rol: assert property (p_rol) else $error("rotate left wrong");
  property p_ror;
    op_done && $past(op_code) == op_rotate_right_carry |-> reg_we && status_flags[0] == $past(reg_in[0])
      && reg_out == {$past(status_flags[0]), $past(reg_in[7:1])} && status_flags[5] == $past(status_flags[5]);
  endproperty
  a_ror: assert property (p_ror) else $error("rotate right wrong");
  property p_asr;
    op_done && $past(op_code) == op_arith_shift_right |-> reg_we && status_flags[0] == $past(reg_in[0])
      && reg_out == {$past(reg_in[7]), $past(reg_in[7:1])} && status_flags[5] == $past(status_flags[5]);
  endproperty
  a_asr: assert property (p_asr) else $error("arith shift wrong");
  property p_znv;
    op_done && $past(op_code) inside {op_rotate_left_carry, op_rotate_right_carry, op_arith_shift_right}
      |-> status_flags[1] == (reg_out == 8'h00) && status_flags[2] == reg_out[7]
      && status_flags[3] == (reg_out[7] ^ status_flags[0]) && status_flags[7:6] == $past(status_flags[7:6]);
  endproperty
  a_znv: assert property (p_znv) else $error("shift flags wrong");
  property p_ioset;
    op_done && $past(op_code) == op_io_bit_set |-> io_we && !reg_we && $stable(status_flags)
      && io_wr_data == ($past(io_data_in) | (8'h01 << $past(bit_sel)));
  endproperty
  a_ioset: assert property (p_ioset) else $error("io set wrong");
  property p_ioclr;
    op_done && $past(op_code) == op_io_bit_clear |-> io_we && !reg_we && $stable(status_flags)
      && io_wr_data == ($past(io_data_in) & ~(8'h01 << $past(bit_sel)));
  endproperty
  a_ioclr: assert property (p_ioclr) else $error("io clear wrong");
  property p_bst;
    op_done && $past(op_code) == op_bit_store_to_transfer |-> !reg_we && !io_we
      && status_flags == {$past(status_flags[7]), $past(reg_in[bit_sel]), $past(status_flags[5:0])};
  endproperty
  a_bst: assert property (p_bst) else $error("bit store wrong");
  property p_bld;
    op_done && $past(op_code) == op_bit_load_from_transfer |-> reg_we && $stable(status_flags)
      && reg_out == ($past(reg_in & ~(8'h01 << bit_sel)) | ({7'h00, $past(status_flags[6])} << $past(bit_sel)));
  endproperty
  a_bld: assert property (p_bld) else $error("bit load wrong");
  property p_flag;
    op_done && $past(op_code) >= op_indexed_flag_set |-> !reg_we && !io_we
      && status_flags == fexp($past(op_code), $past(flag_sel), $past(status_flags));
  endproperty
  a_flag: assert property (p_flag) else $error("flag op wrong");
  property p_mem;
    mem_req && mem_internal_sram && !mem_external && mem_base_cycles == 4'h2 |=> !mem_done [*3] ##1 mem_done;
  endproperty
  a_mem: assert property (p_mem) else $error("sram timing wrong");
endmodule

bind bit_shift_flag_unit bit_shift_flag_unit_chk u_chk (.sys_clk, .rst_b, .op_valid, .op_code, .reg_in,
  .bit_sel, .flag_sel, .io_data_in, .io_wr_data, .io_we, .reg_out, .reg_we, .op_done, .status_flags,
  .mem_req, .mem_base_cycles, .mem_internal_sram, .mem_external, .mem_done);

// ===== tb/bit_shift_flag_unit_bench.sv
`timescale 1ns/1ps
module bit_shift_flag_unit_bench
  import bit_shift_flag_pkg::*;
;
  typedef struct packed {logic [1:0] k; logic [7:0] d; logic [7:0] f;} exp_t;
  logic sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, er, en;
  logic op_valid, io_we, reg_we, op_done, mem_req, mem_internal_sram, mem_external, ext_ack, mem_done;
  logic [7:0] paddr, reg_in, io_data_in, io_wr_data, reg_out, status_flags, sf, lr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0] io_addr_in, io_addr, ea;
  logic [2:0] bit_sel, flag_sel;
  logic [3:0] mem_base_cycles;
  op_t op_code;
  exp_t q[$];
  logic [5:0] aq[$];
  exp_t e, m;
  int n_mismatch, check_count, n_exec;

  bit_shift_flag_unit u_dut (.sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .op_valid, .op_code, .reg_in, .bit_sel, .flag_sel, .io_addr_in, .io_data_in, .io_addr,
    .io_wr_data, .io_we, .reg_out, .reg_we, .op_done, .status_flags, .mem_req, .mem_base_cycles,
    .mem_internal_sram, .mem_external, .ext_ack, .mem_done);
  io_space_model u_io (.sys_clk, .rd_addr(io_addr_in), .rd_data(io_data_in), .wr_addr(io_addr),
    .wr_data(io_wr_data), .we(io_we));

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task chk(string nm, logic [31:0] x, logic [31:0] y);
    check_count++;
    if (x !== y)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, x, y);
    end
  endtask

  task stop_test;
    if (n_mismatch == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  function automatic exp_t model(op_t c, logic [7:0] r, io, logic [2:0] b, s, logic [7:0] f);
    exp_t x;
    x = {2'h0, r, f};
    case (c)
      op_none: ;
      op_rotate_left_carry: x = {2'h2, r[6:0], f[0], f[7:6], r[3], f[4:1], r[7]};
      op_rotate_right_carry: x = {2'h2, f[0], r[7:1], f[7:1], r[0]};
      op_arith_shift_right: x = {2'h2, r[7], r[7:1], f[7:1], r[0]};
      op_io_bit_set: x = {2'h1, io | (8'h01 << b), f};
      op_io_bit_clear: x = {2'h1, io & ~(8'h01 << b), f};
      op_bit_store_to_transfer: x.f[6] = r[b];
      op_bit_load_from_transfer: x = {2'h2, (r & ~(8'h01 << b)) | ({7'h00, f[6]} << b), f};
      default: x.f[(c < op_overflow_flag_set) ? s : 3'(24'hdca12b >> (3 * ((int'(c) - 10) / 2)))] = ~c[0];
    endcase
    if (c < op_io_bit_set && c != op_none)
      x.f[3:1] = {x.d[7] ^ x.f[0], x.d[7], x.d == 8'h00};
    return x;
  endfunction

  task apb(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    {pwrite, paddr, pwdata} <= {w, a, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      n_mismatch++;
      stop_test;
    end
  endtask

  // expectation is noted after the io model has answered the new address
  task op(op_t c);
    @(posedge sys_clk);
    op_valid <= 1'b1;
    op_code <= c;
    {reg_in, bit_sel, flag_sel, io_addr_in} <= 20'($urandom);
    #1;
    if (c != op_none && en)
    begin
      e = model(c, reg_in, io_data_in, bit_sel, flag_sel, sf);
      sf = e.f;
      q.push_back(e);
      aq.push_back(io_addr_in);
      if (e.k != 2'h0)
        lr = e.d;
      n_exec++;
    end
    @(posedge sys_clk);
    op_valid <= 1'b0;
  endtask

  task mem(logic [3:0] b, logic s, x, int lo, hi);
    int n;
    @(posedge sys_clk);
    {mem_req, mem_base_cycles, mem_internal_sram, mem_external} <= {1'b1, b, s, x};
    // n counts edges after the one that takes the request
    @(posedge sys_clk);
    mem_req <= 1'b0;
    n = 0;
    do
    begin
      ext_ack <= x && n >= 7;
      @(posedge sys_clk);
      n++;
    end
    while (mem_done !== 1'b1 && n < 40);
    ext_ack <= 1'b0;
    if (mem_done !== 1'b1)
    begin
      n_mismatch++;
      stop_test;
    end
    // pulse is read before its own edge updates it, hence n - 1
    chk("mem_done delay", 32'h1, {31'h0, n - 1 >= lo && n - 1 <= hi});
  endtask

  always @(negedge sys_clk)
    if (op_done === 1'b1)
    begin
      if (q.size() == 0)
        chk("op_done", 32'h0, 32'h1);
      else
      begin
        m = q.pop_front();
        ea = aq.pop_front();
        chk("status_flags", m.f, status_flags);
        chk("write strobes", m.k, {reg_we, io_we});
        if (m.k[1])
          chk("reg_out", m.d, reg_out);
        if (m.k[0])
        begin
          chk("io_wr_data", m.d, io_wr_data);
          chk("io_addr", ea, io_addr);
        end
      end
    end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    {rst_b, psel, penable, pwrite, paddr, pwdata, op_valid, reg_in, bit_sel, flag_sel, io_addr_in} = '0;
    {mem_req, mem_base_cycles, mem_internal_sram, mem_external, ext_ack} = '0;
    op_code = op_none;
    en = 1'b1;
    void'($urandom(82929));
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    apb(1'b0, 8'h04, 32'h0);
    chk("ctrl", 32'h3, rd);
    apb(1'b1, 8'h40, 32'h5);
    chk("unmapped", 32'h1, {31'h0, er});
    sf = 8'($urandom);
    apb(1'b1, 8'h00, {24'h0, sf});
    apb(1'b0, 8'h00, 32'h0);
    chk("status", {24'h0, sf}, rd);
    for (int p = 0; p < 3; p++)
      for (int c = 0; c < 26; c++)
        op(op_t'(c));
    apb(1'b0, 8'h0c, 32'h0);
    chk("last result", lr, rd);
    apb(1'b1, 8'h04, 32'h2);
    en = 1'b0;
    op(op_rotate_left_carry);
    en = 1'b1;
    apb(1'b1, 8'h04, 32'h3);
    apb(1'b1, 8'h08, 32'hff);
    apb(1'b0, 8'h08, 32'h0);
    chk("op count", n_exec, rd);
    mem(4'h2, 1'b1, 1'b0, 3, 3);
    mem(4'h0, 1'b1, 1'b0, 2, 2);
    mem(4'h5, 1'b0, 1'b0, 5, 5);
    mem(4'h2, 1'b1, 1'b1, 8, 10);
    repeat (2) @(posedge sys_clk);
    chk("pending ops", 32'h0, q.size());
    stop_test;
  end

  initial
  begin
    #500000;
    n_mismatch++;
    stop_test;
  end
endmodule
